// >>> fpc_pkg.sv
`default_nettype none
package fpc_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [11:0] OFS_ADDR = 12'h000;
  localparam logic [11:0] OFS_DATA = 12'h004;
  localparam logic [11:0] OFS_CTRL = 12'h008;
  localparam logic [11:0] OFS_RIS  = 12'h00c;
  localparam logic [11:0] OFS_IM   = 12'h010;
  localparam logic [11:0] OFS_MISC = 12'h014;
  localparam logic [11:0] OFS_PRE  = 12'h130;
  localparam logic [11:0] OFS_PPE  = 12'h134;
  localparam logic [11:0] OFS_USEC = 12'h140;
  // ==========================================================
  // control register fields
  localparam logic [15:0] CTRL_KEY   = 16'ha442;
  localparam int          BIT_WRITE  = 0;
  localparam int          BIT_ERASE  = 1;
  localparam int          BIT_MASS   = 2;
  localparam int          BIT_COMMIT = 3;
  localparam int          OP_BITS    = 4;
  // ==========================================================
  // interrupt status fields
  localparam int RIS_ACCESS = 0;
  localparam int RIS_DONE   = 1;
  localparam logic [31:0] RIS_MASK = 32'h0000_0003;
  // ==========================================================
  // protection layout and reset values
  localparam int          NUM_BLOCKS      = 16;
  localparam int          BLOCK_LSB       = 11;
  localparam int          DBG_LSB         = 30;
  localparam logic [1:0]  DBG_OPEN        = 2'h2;
  localparam logic [31:0] PRE_IMPL_MASK   = 32'hc000_ffff;
  localparam logic [31:0] PPE_IMPL_MASK   = 32'h0000_ffff;
  localparam logic [31:0] PRE_RESET       = 32'h8000_ffff;
  localparam logic [31:0] PPE_RESET       = 32'h0000_ffff;
  localparam logic [31:0] DBG_COMMIT_ADDR = 32'h0000_0900;
  localparam int          COMMIT_SEL_BIT  = 0;
  localparam logic [31:0] ADDR_MASK       = 32'h0000_7fff;
  localparam logic [7:0]  USEC_RESET      = 8'h31;
  // ==========================================================
  // operation times in microseconds
  localparam logic [19:0] PROG_US   = 20'h00014;
  localparam logic [19:0] ERASE_US  = 20'h04e20;
  localparam logic [19:0] MASS_US   = 20'h30d40;
  localparam logic [19:0] COMMIT_US = 20'h00014;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } fpc_state_t;
endpackage
`default_nettype wire

// >>> fpc_usec_tick.sv
`timescale 1ns/1ps
`default_nettype none
module fpc_usec_tick (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // reload and tick
  input  wire logic [7:0] reload,
  output logic            tick
);
  logic [7:0] cnt_r;
  wire        at_zero = (cnt_r == 8'h00);

  // ==========================================================
  // divider: one tick every reload+1 clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      tick  <= 1'b0;
    end else begin
      cnt_r <= at_zero ? reload : cnt_r - 8'h01;
      tick  <= at_zero;
    end
  end
endmodule // fpc_usec_tick
`default_nettype wire

// >>> fpc_op_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fpc_op_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // control
  input  wire logic        start,
  input  wire logic [19:0] length,
  input  wire logic        tick,
  // status
  output logic             busy,
  output logic             done
);
  logic [19:0] left_r;

  // ==========================================================
  // counts microsecond ticks; zero length finishes on next tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_r <= 20'h00000;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        left_r <= length;
        busy   <= 1'b1;
      end else if (busy && tick) begin
        if (left_r <= 20'h00001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        left_r <= left_r - 20'h00001;
      end
    end
  end
endmodule // fpc_op_timer
`default_nettype wire

// >>> fpc_sequencer.sv
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module fpc_sequencer #(
  parameter logic [19:0] PROG_TIME   = fpc_pkg::PROG_US,
  parameter logic [19:0] ERASE_TIME  = fpc_pkg::ERASE_US,
  parameter logic [19:0] MASS_TIME   = fpc_pkg::MASS_US,
  parameter logic [19:0] COMMIT_TIME = fpc_pkg::COMMIT_US
) (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // register bus
  input  wire logic [11:0] AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // nonvolatile protection store
  input  wire logic [31:0] NV_READ_ENABLE_IN,
  input  wire logic [31:0] NV_PROGRAM_ENABLE_IN,
  output logic             NV_COMMIT_STROBE,
  output logic             NV_COMMIT_SELECT,
  output logic      [31:0] NV_COMMIT_VALUE,
  // flash array operation
  output logic      [2:0]  ARRAY_OP,
  output logic      [14:0] ARRAY_ADDR,
  output logic      [31:0] ARRAY_DATA,
  // data read gate
  input  wire logic [14:0] FETCH_ADDR,
  input  wire logic [31:0] FETCH_DATA_IN,
  output logic      [31:0] FETCH_DATA_OUT,
  // protection state
  output logic      [15:0] BLOCK_READ_EN,
  output logic      [15:0] BLOCK_PROG_EN,
  output logic             DEBUG_PORT_EN
);
  import fpc_pkg::*;

  // ==========================================================
  // state
  fpc_state_t   state_r, state_nxt;
  logic         ack_r;
  logic [31:0]  addr_r, data_r, pre_r, ppe_r, rdata_nxt;
  logic [31:0]  nv_pre_r, nv_ppe_r;
  logic [OP_BITS-1:0] ctrl_r;
  logic [1:0]   ris_r, im_r;
  logic [7:0]   usec_r;
  logic         tick, op_busy, op_done, op_start_r;
  logic [19:0]  op_len_r;

  // ==========================================================
  // bus decode
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  wire        req      = AVS_READ | AVS_WRITE;
  wire        take     = req & ack_r;
  wire        wr       = take & AVS_WRITE;
  wire [31:0] wmask    = be_mask(AVS_BYTEENABLE);
  wire [31:0] wval     = AVS_WRITEDATA & wmask;
  wire        wr_addr  = wr && AVS_ADDRESS == OFS_ADDR;
  wire        wr_data  = wr && AVS_ADDRESS == OFS_DATA;
  wire        wr_ctrl  = wr && AVS_ADDRESS == OFS_CTRL;
  wire        wr_im    = wr && AVS_ADDRESS == OFS_IM;
  wire        wr_misc  = wr && AVS_ADDRESS == OFS_MISC;
  wire        wr_pre   = wr && AVS_ADDRESS == OFS_PRE;
  wire        wr_ppe   = wr && AVS_ADDRESS == OFS_PPE;
  wire        wr_usec  = wr && AVS_ADDRESS == OFS_USEC;
  wire [1:0]  mis      = ris_r & im_r;

  // ==========================================================
  // operation launch
  // key must be whole: a write missing the upper lanes is not keyed
  wire key_ok   = AVS_BYTEENABLE[3] & AVS_BYTEENABLE[2] &
                  (AVS_WRITEDATA[31:16] == CTRL_KEY);
  wire [OP_BITS-1:0] op_req = AVS_WRITEDATA[OP_BITS-1:0];
  // a second launch while busy is dropped; polling software never does it
  wire launch   = wr_ctrl & key_ok & AVS_BYTEENABLE[0] &
                  (op_req != 4'h0) & (state_r == ST_IDLE);
  wire [3:0]  blk     = addr_r[BLOCK_LSB +: 4];
  wire        blk_ok  = ppe_r[blk];
  // whole-array erase needs every block program-enabled
  wire        all_ok  = &ppe_r[NUM_BLOCKS-1:0];
  wire        is_prog = op_req[BIT_WRITE] | op_req[BIT_ERASE];
  wire        is_commit_request_bit = op_req[BIT_COMMIT];
  wire        violate = launch & ~is_commit_request_bit &
                        (is_prog ? ~blk_ok : ~all_ok);
  wire        dbg_commit = addr_r == DBG_COMMIT_ADDR;
  wire        sel_ppe = ~dbg_commit & addr_r[COMMIT_SEL_BIT];
  // normal read-enable commit keeps the stored debug field
  wire [31:0] pre_commit = dbg_commit ? pre_r :
      {nv_pre_r[31:DBG_LSB], pre_r[DBG_LSB-1:0]};
  wire [31:0] commit_val = sel_ppe ? ppe_r :
      (pre_commit & nv_pre_r);
  wire [19:0] len_sel = is_commit_request_bit ? COMMIT_TIME :
      op_req[BIT_MASS] ? MASS_TIME :
      op_req[BIT_ERASE] ? ERASE_TIME : PROG_TIME;
  wire        op_end  = (state_r == ST_RUN) & op_done;

  // ==========================================================
  // read mux
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (AVS_ADDRESS)
      OFS_ADDR: rdata_nxt = addr_r;
      OFS_DATA: rdata_nxt = data_r;
      OFS_CTRL: rdata_nxt = {28'h000_0000, ctrl_r};
      OFS_RIS:  rdata_nxt = {30'h0000_0000, ris_r};
      OFS_IM:   rdata_nxt = {30'h0000_0000, im_r};
      OFS_MISC: rdata_nxt = {30'h0000_0000, mis};
      OFS_PRE:  rdata_nxt = pre_r & PRE_IMPL_MASK;
      OFS_PPE:  rdata_nxt = ppe_r & PPE_IMPL_MASK;
      OFS_USEC: rdata_nxt = {24'h00_0000, usec_r};
      default:  rdata_nxt = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_LOAD: state_nxt = ST_IDLE;
      ST_IDLE: if (launch && !violate) state_nxt = ST_RUN;
      ST_RUN:  if (op_done) state_nxt = ST_IDLE;
      default: state_nxt = ST_LOAD;
    endcase
  end

  // ==========================================================
  // bus slave: answer one cycle after request appears
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_r           <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else begin
      ack_r           <= req & ~ack_r;
      AVS_WAITREQUEST <= ~(req & ~ack_r);
      AVS_READDATA    <= (AVS_READ & ~ack_r) ? rdata_nxt : 32'h0000_0000;
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      addr_r <= 32'h0000_0000;
      data_r <= 32'h0000_0000;
      im_r   <= 2'h0;
      usec_r <= USEC_RESET;
    end else begin
      if (wr_addr) addr_r <= ((addr_r & ~wmask) | wval) & ADDR_MASK;
      if (wr_data) data_r <= (data_r & ~wmask) | wval;
      if (wr_im)   im_r   <= (im_r & ~wmask[1:0]) | wval[1:0];
      if (wr_usec) usec_r <= (usec_r & ~wmask[7:0]) | wval[7:0];
    end
  end

  // ==========================================================
  // protection: factory value until the store is sampled
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pre_r    <= PRE_RESET;
      ppe_r    <= PPE_RESET;
      nv_pre_r <= PRE_RESET;
      nv_ppe_r <= PPE_RESET;
    end else if (state_r == ST_LOAD) begin
      // reload drops any uncommitted volatile change
      pre_r    <= NV_READ_ENABLE_IN & PRE_IMPL_MASK;
      ppe_r    <= NV_PROGRAM_ENABLE_IN & PPE_IMPL_MASK;
      nv_pre_r <= NV_READ_ENABLE_IN & PRE_IMPL_MASK;
      nv_ppe_r <= NV_PROGRAM_ENABLE_IN & PPE_IMPL_MASK;
    end else begin
      if (wr_pre) pre_r <= pre_r & (wval | ~wmask);
      if (wr_ppe) ppe_r <= ppe_r & (wval | ~wmask);
      if (op_end && ctrl_r[BIT_COMMIT]) begin
        if (NV_COMMIT_SELECT) nv_ppe_r <= NV_COMMIT_VALUE;
        else nv_pre_r <= NV_COMMIT_VALUE;
      end
    end
  end

  // ==========================================================
  // control and status
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r    <= ST_LOAD;
      ctrl_r     <= 4'h0;
      ris_r      <= 2'h0;
      op_start_r <= 1'b0;
      op_len_r   <= 20'h00000;
    end else begin
      state_r    <= state_nxt;
      op_start_r <= launch & ~violate;
      if (launch) op_len_r <= len_sel;
      if (launch && !violate) ctrl_r <= op_req;
      else if (op_end) ctrl_r <= 4'h0;
      // set wins over a simultaneous clear
      ris_r[RIS_ACCESS] <= violate |
          (ris_r[RIS_ACCESS] & ~(wr_misc & wval[RIS_ACCESS]));
      ris_r[RIS_DONE] <= op_end | violate |
          (ris_r[RIS_DONE] & ~(wr_misc & wval[RIS_DONE]));
    end
  end

  // ==========================================================
  // array and store outputs
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ARRAY_OP         <= 3'h0;
      ARRAY_ADDR       <= 15'h0000;
      ARRAY_DATA       <= 32'h0000_0000;
      NV_COMMIT_STROBE <= 1'b0;
      NV_COMMIT_SELECT <= 1'b0;
      NV_COMMIT_VALUE  <= PRE_RESET;
    end else begin
      NV_COMMIT_STROBE <= launch & is_commit_request_bit;
      if (launch && is_commit_request_bit) begin
        NV_COMMIT_SELECT <= sel_ppe;
        NV_COMMIT_VALUE  <= commit_val;
      end
      if (launch && !violate && !is_commit_request_bit) begin
        ARRAY_OP   <= op_req[2:0];
        ARRAY_ADDR <= op_req[BIT_ERASE] ? {addr_r[14:10], 10'h000} :
                      addr_r[14:0];
        ARRAY_DATA <= data_r;
      end else if (op_end) begin
        ARRAY_OP <= 3'h0;
      end
    end
  end

  // ==========================================================
  // access gates
  wire [3:0] fetch_blk = FETCH_ADDR[BLOCK_LSB +: 4];
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FETCH_DATA_OUT <= 32'h0000_0000;
      BLOCK_READ_EN  <= 16'h0000;
      BLOCK_PROG_EN  <= 16'h0000;
      DEBUG_PORT_EN  <= 1'b0;
    end else begin
      FETCH_DATA_OUT <= pre_r[fetch_blk] ? FETCH_DATA_IN :
                        32'h0000_0000;
      BLOCK_READ_EN  <= pre_r[NUM_BLOCKS-1:0];
      BLOCK_PROG_EN  <= ppe_r[NUM_BLOCKS-1:0];
      DEBUG_PORT_EN  <= pre_r[31:DBG_LSB] == DBG_OPEN;
    end
  end

  // ==========================================================
  // timing
  fpc_usec_tick u_tick (
    .clk    (CLOCK),
    .rst    (SYS_RST),
    .reload (usec_r),
    .tick   (tick)
  );

  fpc_op_timer u_timer (
    .clk    (CLOCK),
    .rst    (SYS_RST),
    .start  (op_start_r),
    .length (op_len_r),
    .tick   (tick),
    .busy   (op_busy),
    .done   (op_done)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  chk_key_gate: assert property (
    wr_ctrl && !key_ok && state_r == ST_IDLE |=>
    ctrl_r == 4'h0 && state_r == ST_IDLE &&
    ARRAY_OP == 3'h0 && !NV_COMMIT_STROBE)
    else $error("unkeyed control write started an operation");
  chk_pre_oneway: assert property (
    state_r != ST_LOAD && $past(state_r) != ST_LOAD |->
    (pre_r & ~$past(pre_r)) == 32'h0)
    else $error("read-enable bit rose");
  chk_ppe_oneway: assert property (
    state_r == ST_IDLE |=> (ppe_r & ~$past(ppe_r)) == 32'h0)
    else $error("program-enable bit rose");
  chk_commit_clear: assert property (
    ctrl_r[BIT_COMMIT] && op_done |=> ctrl_r == 4'h0 && state_r == ST_IDLE)
    else $error("commit bit not cleared at end");
  chk_commit_busy: assert property (
    launch && !violate && is_commit_request_bit |=> ctrl_r[BIT_COMMIT] [*2])
    else $error("commit bit not held while running");
  chk_viol_flag: assert property (
    violate |=> ris_r[RIS_ACCESS] && ctrl_r == 4'h0 && ARRAY_OP == $past(ARRAY_OP))
    else $error("violation not flagged or array touched");
  chk_read_block: assert property (
    !pre_r[fetch_blk] |=> FETCH_DATA_OUT == 32'h0)
    else $error("protected block data leaked");
  chk_done_flag: assert property (
    op_end |=> ris_r[RIS_DONE])
    else $error("done flag missing");
  chk_commit_sel: assert property (
    launch && is_commit_request_bit && !dbg_commit |=>
    NV_COMMIT_STROBE && NV_COMMIT_SELECT == $past(addr_r[0]))
    else $error("commit target wrong");
  chk_dbg_port: assert property (
    pre_r[31:30] == 2'b00 |=> !DEBUG_PORT_EN)
    else $error("debug port open with field clear");

  cov_program: cover property (launch && op_req == 4'h1 ##[1:1000] op_end);
  cov_commit: cover property (launch && is_commit_request_bit && dbg_commit);
  cov_violate: cover property (violate);
  cov_clear: cover property (wr_misc && ris_r != 2'h0);
endmodule // fpc_sequencer
`default_nettype wire

// >>> test_fpc_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_fpc_sequencer;
  import fpc_pkg::*;
  // ==========================================================
  // short op times and a fast tick keep the run brief
  localparam int T = 4;
  localparam int U = 9;
  logic        clock, sys_rst, rd, wr, wait_req, cm_stb, cm_sel, dbg_en;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, nv_re, nv_pe, cm_val, f_in, f_out;
  logic [3:0]  be;
  logic [2:0]  a_op, seen_op;
  logic [14:0] a_addr, f_addr, seen_addr;
  logic [31:0] a_data, seen_data, c_val, q, d, lfsr_r;
  logic        c_sel;
  logic [15:0] rd_en, pg_en;
  logic [11:0] ofs[10];
  logic [31:0] rst_val[10];
  int          bad_count, tests_run, op_cycles, n_commit;

  fpc_sequencer #(
    .PROG_TIME  (20'h4),
    .ERASE_TIME (20'h4),
    .MASS_TIME  (20'h4),
    .COMMIT_TIME(20'h4)
  ) dut (
    .CLOCK(clock), .SYS_RST(sys_rst),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
    .NV_READ_ENABLE_IN(nv_re), .NV_PROGRAM_ENABLE_IN(nv_pe),
    .NV_COMMIT_STROBE(cm_stb), .NV_COMMIT_SELECT(cm_sel),
    .NV_COMMIT_VALUE(cm_val),
    .ARRAY_OP(a_op), .ARRAY_ADDR(a_addr), .ARRAY_DATA(a_data),
    .FETCH_ADDR(f_addr), .FETCH_DATA_IN(f_in), .FETCH_DATA_OUT(f_out),
    .BLOCK_READ_EN(rd_en), .BLOCK_PROG_EN(pg_en), .DEBUG_PORT_EN(dbg_en)
  );

  // ==========================================================
  // expectation helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] prot(input logic [31:0] o, w, m);
    return o & w & m;
  endfunction
  // tick phase at launch is unknown, so allow one tick either way
  function automatic logic [31:0] in_span(input int c);
    return {31'h0, (c >= (T - 1) * (U + 1) && c <= (T + 1) * (U + 1) + 2)};
  endfunction

  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] dv);
    int n;
    @(posedge clock);
    addr  <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= dv;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    q = rdata;
    if (n >= 50) bad_count++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask
  task automatic op(input logic [31:0] ctl, rb, ris);
    int n;
    bus(1'b1, OFS_MISC, 32'h3);
    op_cycles = 0;
    seen_op = 3'h0;
    bus(1'b1, OFS_CTRL, ctl);
    rchk(OFS_CTRL, rb);
    n = 0;
    while (q !== 32'h0 && n < 200) begin
      bus(1'b0, OFS_CTRL, 32'h0);
      n++;
    end
    check(q, 32'h0);
    rchk(OFS_RIS, ris);
  endtask
  task automatic fetch(input logic [14:0] fa, input logic zero);
    lfsr_r = lfsr(lfsr_r);
    @(posedge clock);
    f_addr <= fa;
    f_in   <= lfsr_r;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check(f_out, zero ? 32'h0 : lfsr_r);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // monitors: array activity and the nonvolatile store itself
  always @(posedge clock) begin
    if (a_op !== 3'h0) begin
      op_cycles++;
      seen_op   = seen_op | a_op;
      seen_addr = a_addr;
      seen_data = a_data;
    end
    if (cm_stb === 1'b1) begin
      n_commit++;
      c_sel = cm_sel;
      c_val = cm_val;
      if (cm_sel) nv_pe <= cm_val;
      else nv_re <= cm_val;
    end
  end

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    finish_test;
  end

  // ==========================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    addr = 12'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    be = 4'hf;
    nv_re = PRE_RESET;
    nv_pe = PPE_RESET;
    f_addr = 15'h0;
    f_in = 32'h0;
    bad_count = 0;
    tests_run = 0;
    n_commit = 0;
    lfsr_r = 32'h0000_049e;
    ofs = '{OFS_ADDR, OFS_DATA, OFS_CTRL, OFS_RIS, OFS_IM, OFS_MISC,
            OFS_PRE, OFS_PPE, OFS_USEC, 12'h018};
    rst_val = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                PRE_RESET, PPE_RESET, 32'h31, 32'h0};
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 10; i++) rchk(ofs[i], rst_val[i]);
    check({31'h0, dbg_en}, 32'h1);
    check({pg_en, rd_en}, 32'hffff_ffff);
    bus(1'b1, OFS_USEC, U);
    rchk(OFS_USEC, U);
    bus(1'b1, OFS_IM, 32'h3);
    op(32'ha442_0004, 32'h4, 32'h2);
    check({29'h0, seen_op}, 32'h4);
    check(in_span(op_cycles), 32'h1);
    bus(1'b1, OFS_PPE, 32'hffff_fffe);
    rchk(OFS_PPE, prot(PPE_RESET, 32'hfffe, PPE_IMPL_MASK));
    lfsr_r = lfsr(lfsr_r);
    d = lfsr_r;
    bus(1'b1, OFS_DATA, d);
    bus(1'b1, OFS_ADDR, 32'h0000_0804);
    op(32'ha442_0001, 32'h1, 32'h2);
    check({seen_op, seen_addr, seen_data[13:0]},
          {3'h1, 15'h0804, d[13:0]});
    check(seen_data, d);
    bus(1'b1, OFS_IM, 32'h0);
    rchk(OFS_MISC, 32'h0);
    bus(1'b1, OFS_IM, 32'h2);
    rchk(OFS_MISC, 32'h2);
    bus(1'b1, OFS_MISC, 32'h2);
    rchk(OFS_RIS, 32'h0);
    bus(1'b1, OFS_IM, 32'h3);
    bus(1'b1, OFS_ADDR, 32'h0000_0c00);
    op(32'ha442_0002, 32'h2, 32'h2);
    check({17'h0, seen_op, seen_addr[11:0]}, {17'h0, 3'h2, 12'hc00});
    bus(1'b1, OFS_ADDR, 32'h0000_0010);
    op(32'ha442_0001, 32'h0, 32'h3);
    check({29'h0, seen_op}, 32'h0);
    op(32'h1234_0001, 32'h0, 32'h0);
    check({29'h0, seen_op}, 32'h0);
    bus(1'b1, OFS_PPE, 32'hffff_fff7);
    rchk(OFS_PPE, prot(32'hfffe, 32'hfff7, PPE_IMPL_MASK));
    bus(1'b1, OFS_ADDR, 32'h1);
    op(32'ha442_0008, 32'h8, 32'h2);
    check({c_sel, c_val[30:0]}, {1'b1, 31'h0000_fff6});
    bus(1'b1, OFS_PRE, 32'hffff_fffd);
    rchk(OFS_PRE, prot(PRE_RESET, 32'hffff_fffd, PRE_IMPL_MASK));
    fetch(15'h0804, 1'b1);
    fetch(15'h1000, 1'b0);
    bus(1'b1, OFS_ADDR, 32'h0);
    op(32'ha442_0008, 32'h8, 32'h2);
    check({c_sel, c_val[30:0]}, {1'b0, 31'h0000_fffd});
    check(c_val, 32'h8000_fffd);
    bus(1'b1, OFS_PRE, 32'h3fff_ffff);
    rchk(OFS_PRE, 32'h0000_fffd);
    check({31'h0, dbg_en}, 32'h0);
    bus(1'b1, OFS_ADDR, DBG_COMMIT_ADDR);
    op(32'ha442_0008, 32'h8, 32'h2);
    check(c_val, 32'h0000_fffd);
    bus(1'b1, OFS_PRE, 32'h0000_ff00);
    rchk(OFS_PRE, prot(32'h0000_fffd, 32'h0000_ff00, PRE_IMPL_MASK));
    // second power-on: uncommitted clears must be gone
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    rchk(OFS_PRE, 32'h0000_fffd);
    rchk(OFS_PPE, 32'h0000_fff6);
    check({pg_en, rd_en}, {16'hfff6, 16'hfffd});
    check({31'h0, dbg_en}, 32'h0);
    check(n_commit, 32'h3);
    bus(1'b1, OFS_ADDR, 32'h0000_1800);
    op(32'ha442_0001, 32'h0, 32'h3);
    finish_test;
  end
endmodule // test_fpc_sequencer
`default_nettype wire
